//--- hw/ras_stack.sv
`timescale 1ns/1ps
`default_nettype none
module ras_stack
  import ras_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // Configuration
  input  wire logic                  stack_reset_enable,
  // Instruction sequencer
  input  wire ras_pkg::ras_seq_t     seq_in,
  output logic [14:0]                pop_pc,
  // Register bus
  input  wire ras_pkg::ras_bus_t     bus_in,
  output logic [7:0]                 rdata,
  // Status
  output logic [4:0]                 stack_pointer,
  output logic                       stack_overflow_flag,
  output logic                       stack_underflow_flag,
  output logic                       stack_reset_req
);
  import ras_pkg::*;

  logic [14:0] mem_r [RAS_DEPTH];
  logic [4:0]  sp_r;
  logic [4:0]  sp_nxt;
  logic [14:0] pop_pc_r;
  logic [7:0]  rdata_r;
  logic        ovf_r;
  logic        unf_r;
  logic        rst_req_r;
  logic        fault_pend_r;
  logic        push_ovf;
  logic        pop_unf;
  logic        sp_empty;
  logic [14:0] top_val;

  // Entry index from the low pointer bits
  function automatic logic [3:0] slot(input logic [4:0] p);
    return p[3:0];
  endfunction

  // Stack state classification
  assign sp_empty = (sp_r == RAS_SP_RESET);
  assign push_ovf = seq_in.push && (sp_r == RAS_SP_TOP);
  assign pop_unf  = seq_in.pop && sp_empty;

  // Top entry view seen by software
  always_comb begin
    if (sp_empty && stack_reset_enable) begin
      top_val = '0;
    end else if (sp_empty) begin
      top_val = mem_r[RAS_EMPTY_IDX];
    end else begin
      top_val = mem_r[slot(sp_r)];
    end
  end

  // Pointer next value; push has priority over a software write
  always_comb begin
    sp_nxt = sp_r;
    if (seq_in.push) begin
      sp_nxt = (sp_r == RAS_SP_TOP) ? 5'h00 : sp_r + 5'h01;
    end else if (seq_in.pop) begin
      sp_nxt = sp_r - 5'h01;
    end else if (bus_in.wr && bus_in.addr == RAS_A_PTR) begin
      sp_nxt = bus_in.wdata[4:0];
    end
  end

  // Stack pointer register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sp_r <= RAS_SP_RESET;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  // Entry storage: push writes at the incremented slot, software edits the top
  always_ff @(posedge ref_clk) begin
    if (seq_in.push) begin
      mem_r[slot(sp_nxt)] <= seq_in.pc;
    end else if (!seq_in.pop && bus_in.wr && !sp_empty) begin
      if (bus_in.addr == RAS_A_LOW) begin
        mem_r[slot(sp_r)][7:0] <= bus_in.wdata;
      end else if (bus_in.addr == RAS_A_HIGH) begin
        mem_r[slot(sp_r)][14:8] <= bus_in.wdata[6:0];
      end
    end
  end

  // Return address, read before the pointer moves; latch high is not here
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pop_pc_r <= '0;
    end else if (seq_in.pop) begin
      pop_pc_r <= top_val;
    end
  end

  // Sticky flags; hardware set wins over software clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
    end else begin
      if (push_ovf) begin
        ovf_r <= 1'b1;
      end else if (bus_in.wr && bus_in.addr == RAS_A_STATUS && !bus_in.wdata[RAS_ST_OVF]) begin
        ovf_r <= 1'b0;
      end
      if (pop_unf) begin
        unf_r <= 1'b1;
      end else if (bus_in.wr && bus_in.addr == RAS_A_STATUS && !bus_in.wdata[RAS_ST_UNF]) begin
        unf_r <= 1'b0;
      end
    end
  end

  // Fault seen at this edge, held one cycle so the flag is already set
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fault_pend_r <= 1'b0;
    end else begin
      fault_pend_r <= stack_reset_enable && (push_ovf || pop_unf);
    end
  end

  // Reset request one cycle after the flag sets
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rst_req_r <= 1'b0;
    end else begin
      rst_req_r <= stack_reset_enable && fault_pend_r;
    end
  end

  // Register read data, valid the cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (bus_in.rd) begin
      unique case (bus_in.addr)
        RAS_A_LOW:    rdata_r <= top_val[7:0];
        RAS_A_HIGH:   rdata_r <= {1'b0, top_val[14:8]};
        RAS_A_PTR:    rdata_r <= {3'h0, sp_r};
        RAS_A_STATUS: rdata_r <= {6'h00, unf_r, ovf_r};
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  // Outputs
  assign pop_pc               = pop_pc_r;
  assign rdata                = rdata_r;
  assign stack_pointer        = sp_r;
  assign stack_overflow_flag  = ovf_r;
  assign stack_underflow_flag = unf_r;
  assign stack_reset_req      = rst_req_r;

  // Checks: reset state

  // Pointer sits at the empty code on the first edge after release
  a_reset_ptr_empty: assert property (@(posedge ref_clk)
    $fell(rst) |-> sp_r == RAS_SP_RESET)
    else $error("pointer not 1f after reset");

  // Flags and request come out of reset clear
  a_reset_flags_clear: assert property (@(posedge ref_clk)
    $fell(rst) |-> !ovf_r && !unf_r && !rst_req_r)
    else $error("flags not clear after reset");

  // Checks: sequencer pushes and pops

  // Push below the top moves the pointer up by one
  a_push_increments: assert property (@(posedge ref_clk) disable iff (rst)
    seq_in.push && sp_r < RAS_SP_TOP |=> sp_r == $past(sp_r) + 5'h01)
    else $error("push did not increment pointer");

  // Pushed address lands in the slot the pointer now names
  a_push_stores_pc: assert property (@(posedge ref_clk) disable iff (rst)
    seq_in.push |=> mem_r[slot(sp_r)] == $past(seq_in.pc))
    else $error("push did not store pc");

  // Pop alone moves the pointer down by one
  a_pop_decrements: assert property (@(posedge ref_clk) disable iff (rst)
    seq_in.pop && !seq_in.push |=> sp_r == $past(sp_r) - 5'h01)
    else $error("pop did not decrement pointer");

  // Pop hands back the entry read before the pointer moved
  a_pop_returns_top: assert property (@(posedge ref_clk) disable iff (rst)
    seq_in.pop |=> pop_pc == $past(top_val))
    else $error("pop returned wrong address");

  // Return address holds between pops
  a_pop_pc_holds: assert property (@(posedge ref_clk) disable iff (rst)
    !seq_in.pop |=> $stable(pop_pc))
    else $error("return address moved without pop");

  // Pop from slot zero empties the stack
  a_pop_to_empty: assert property (@(posedge ref_clk) disable iff (rst)
    seq_in.pop && !seq_in.push && sp_r == 5'h00 |=> sp_empty)
    else $error("pop from slot zero did not empty");

  // Push from empty lands in slot zero
  a_push_from_empty: assert property (@(posedge ref_clk) disable iff (rst)
    seq_in.push && sp_empty |=> sp_r == 5'h00)
    else $error("push from empty not at slot zero");

  // Checks: overflow and underflow

  // Push at the top wraps to slot zero and flags it
  a_wrap_at_top: assert property (@(posedge ref_clk) disable iff (rst)
    push_ovf |=> sp_r == 5'h00 && ovf_r)
    else $error("push at top did not wrap and flag");

  // Overflow flag set whatever the enable says
  a_overflow_flag: assert property (@(posedge ref_clk) disable iff (rst)
    push_ovf |=> ovf_r)
    else $error("overflow flag not set");

  // Underflow flag set whatever the enable says
  a_underflow_flag: assert property (@(posedge ref_clk) disable iff (rst)
    pop_unf |=> unf_r)
    else $error("underflow flag not set");

  // Pop on an empty stack leaves the pointer one below empty
  a_underflow_ptr: assert property (@(posedge ref_clk) disable iff (rst)
    pop_unf && !seq_in.push |=> sp_r == RAS_SP_RESET - 5'h01)
    else $error("underflow pointer wrong");

  // Software clear of overflow when no new overflow
  a_ovf_clear: assert property (@(posedge ref_clk) disable iff (rst)
    bus_in.wr && bus_in.addr == RAS_A_STATUS && !bus_in.wdata[RAS_ST_OVF] && !push_ovf |=> !ovf_r)
    else $error("overflow flag not cleared");

  // Software clear of underflow when no new underflow
  a_unf_clear: assert property (@(posedge ref_clk) disable iff (rst)
    bus_in.wr && bus_in.addr == RAS_A_STATUS && !bus_in.wdata[RAS_ST_UNF] && !pop_unf |=> !unf_r)
    else $error("underflow flag not cleared");

  // Checks: reset request

  // Overflow with the enable held raises the request two edges on
  a_reset_request: assert property (@(posedge ref_clk) disable iff (rst)
    push_ovf && stack_reset_enable ##1 stack_reset_enable |=> stack_reset_req)
    else $error("no reset request after overflow");

  // Underflow with the enable held raises the request two edges on
  a_reset_req_unf: assert property (@(posedge ref_clk) disable iff (rst)
    pop_unf && stack_reset_enable ##1 stack_reset_enable |=> stack_reset_req)
    else $error("no reset request after underflow");

  // Circular mode never asks for a reset
  a_no_req_disabled: assert property (@(posedge ref_clk) disable iff (rst)
    !stack_reset_enable |=> !stack_reset_req)
    else $error("reset request while disabled");

  // A request only follows a flagged fault
  a_req_after_flag: assert property (@(posedge ref_clk) disable iff (rst)
    stack_reset_req |-> $past(ovf_r || unf_r))
    else $error("reset request without flag");

  // Checks: top entry access

  // Empty stack with reset enabled reads zero low
  a_empty_read_zero: assert property (@(posedge ref_clk) disable iff (rst)
    sp_empty && stack_reset_enable && bus_in.rd && bus_in.addr == RAS_A_LOW |=> rdata == 8'h00)
    else $error("empty stack read not zero");

  // Empty stack with reset enabled reads zero high
  a_empty_high_zero: assert property (@(posedge ref_clk) disable iff (rst)
    sp_empty && stack_reset_enable && bus_in.rd && bus_in.addr == RAS_A_HIGH |=> rdata == 8'h00)
    else $error("empty stack high read not zero");

  // Empty stack in circular mode shows slot 0e
  a_empty_reads_slot: assert property (@(posedge ref_clk) disable iff (rst)
    sp_empty && !stack_reset_enable && bus_in.rd && bus_in.addr == RAS_A_LOW
    |=> rdata == $past(mem_r[RAS_EMPTY_IDX][7:0]))
    else $error("empty stack did not show slot 0e");

  // Writes to the top entry of an empty stack are dropped
  a_no_write_empty: assert property (@(posedge ref_clk) disable iff (rst)
    sp_empty && bus_in.wr && !seq_in.push |=> $stable(mem_r[RAS_EMPTY_IDX]))
    else $error("empty stack slot written");

  // Low register reads the slot under the pointer
  a_top_read_low: assert property (@(posedge ref_clk) disable iff (rst)
    !sp_empty && bus_in.rd && bus_in.addr == RAS_A_LOW |=> rdata == $past(mem_r[slot(sp_r)][7:0]))
    else $error("low read wrong");

  // High register reads the slot under the pointer, bit 7 zero
  a_top_read_high: assert property (@(posedge ref_clk) disable iff (rst)
    !sp_empty && bus_in.rd && bus_in.addr == RAS_A_HIGH
    |=> rdata == {1'b0, $past(mem_r[slot(sp_r)][14:8])})
    else $error("high read wrong");

  // Low register write edits the slot under the pointer
  a_top_write_low: assert property (@(posedge ref_clk) disable iff (rst)
    bus_in.wr && bus_in.addr == RAS_A_LOW && !seq_in.push && !seq_in.pop && !sp_empty
    |=> mem_r[slot(sp_r)][7:0] == $past(bus_in.wdata))
    else $error("low write lost");

  // High register write edits the slot under the pointer
  a_top_write_high: assert property (@(posedge ref_clk) disable iff (rst)
    bus_in.wr && bus_in.addr == RAS_A_HIGH && !seq_in.push && !seq_in.pop && !sp_empty
    |=> mem_r[slot(sp_r)][14:8] == $past(bus_in.wdata[6:0]))
    else $error("high write lost");

  // Checks: pointer and status registers

  // Software pointer write takes the five low bits
  a_sw_ptr_write: assert property (@(posedge ref_clk) disable iff (rst)
    bus_in.wr && bus_in.addr == RAS_A_PTR && !seq_in.push && !seq_in.pop
    |=> sp_r == $past(bus_in.wdata[4:0]))
    else $error("pointer write lost");

  // Pointer read returns the five bit pointer
  a_ptr_read: assert property (@(posedge ref_clk) disable iff (rst)
    bus_in.rd && bus_in.addr == RAS_A_PTR |=> rdata == {3'h0, $past(sp_r)})
    else $error("pointer read wrong");

  // Status read returns both flags
  a_status_read: assert property (@(posedge ref_clk) disable iff (rst)
    bus_in.rd && bus_in.addr == RAS_A_STATUS |=> rdata == {6'h00, $past(unf_r), $past(ovf_r)})
    else $error("status read wrong");

  // Read data is zero outside the cycle after a read
  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !bus_in.rd |=> rdata == 8'h00)
    else $error("read data not idle");

  // Covers for the main scenarios

  // Call followed by return
  c_push_pop: cover property (@(posedge ref_clk) disable iff (rst) seq_in.push ##1 seq_in.pop);

  // Seventeenth push wrapping
  c_overflow: cover property (@(posedge ref_clk) disable iff (rst) push_ovf);

  // Return on an empty stack
  c_underflow: cover property (@(posedge ref_clk) disable iff (rst) pop_unf);

  // Software moving the pointer
  c_sw_ptr: cover property (@(posedge ref_clk) disable iff (rst) bus_in.wr && bus_in.addr == RAS_A_PTR);

  // Fault turning into a reset request
  c_reset_req: cover property (@(posedge ref_clk) disable iff (rst) stack_reset_req);
endmodule
`default_nettype wire

//--- hw/ras_pkg.sv
package ras_pkg;
  // Stack geometry
  localparam int          RAS_DEPTH     = 16;
  localparam int          RAS_AW        = 4;
  localparam int          RAS_PC_W      = 15;
  localparam int          RAS_SP_W      = 5;
  localparam int          RAS_HI_W      = 7;
  // Reset and special pointer values
  localparam logic [4:0]  RAS_SP_RESET  = 5'h1f;
  localparam logic [4:0]  RAS_SP_TOP    = 5'h0f;
  localparam logic [3:0]  RAS_EMPTY_IDX = 4'he;
  // Register addresses
  localparam int          RAS_ADDR_W    = 2;
  localparam logic [1:0]  RAS_A_LOW     = 2'h0;
  localparam logic [1:0]  RAS_A_HIGH    = 2'h1;
  localparam logic [1:0]  RAS_A_PTR     = 2'h2;
  localparam logic [1:0]  RAS_A_STATUS  = 2'h3;
  // Status field positions
  localparam int          RAS_ST_OVF    = 0;
  localparam int          RAS_ST_UNF    = 1;

  // Sequencer request bundle
  typedef struct packed {
    logic                push;
    logic                pop;
    logic [14:0]         pc;
  } ras_seq_t;

  // Register bus request bundle
  typedef struct packed {
    logic [1:0]          addr;
    logic [7:0]          wdata;
    logic                wr;
    logic                rd;
  } ras_bus_t;
endpackage

//--- sim/ras_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module ras_seq_model
  import ras_pkg::*;
(
  // Core clock
  input  wire logic         ref_clk,
  // Requests toward the stack
  output var ras_pkg::ras_seq_t seq_out
);
  initial seq_out = '0;

  // Call or interrupt push, one cycle, then pc scrambled
  task automatic call_push(input logic [14:0] pc);
    @(posedge ref_clk);
    seq_out <= '{push: 1'b1, pop: 1'b0, pc: pc};
    @(posedge ref_clk);
    seq_out <= '{push: 1'b0, pop: 1'b0, pc: ~pc};
  endtask

  // Return pop; never issued while the bench moves the pointer
  task automatic ret_pop();
    @(posedge ref_clk);
    seq_out.pop <= 1'b1;
    @(posedge ref_clk);
    seq_out.pop <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- sim/tb_return_address_stack.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module tb_return_address_stack;
  import ras_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        stack_reset_enable = 1'b0;
  ras_seq_t    seq_in;
  ras_bus_t    bus_in = '0;
  logic [14:0] pop_pc;
  logic [7:0]  rdata;
  logic [4:0]  stack_pointer;
  logic        ovf;
  logic        unf;
  logic        rreq;
  int          n_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;
  // Pushed address beside the pointer it should leave
  logic [19:0] rows [4] = '{{15'h4321, 5'h00}, {15'h7fff, 5'h01}, {15'h0a5c, 5'h02}, {15'h1234, 5'h03}};

  // Clock and hang guard
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  ras_seq_model seq (.ref_clk(ref_clk), .seq_out(seq_in));
  ras_stack dut (.ref_clk(ref_clk), .rst(rst), .stack_reset_enable(stack_reset_enable),
    .seq_in(seq_in), .pop_pc(pop_pc), .bus_in(bus_in), .rdata(rdata),
    .stack_pointer(stack_pointer), .stack_overflow_flag(ovf),
    .stack_underflow_flag(unf), .stack_reset_req(rreq));

  // Register bus cycles
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_in.wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_in.rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask

  task automatic tally_and_finish();
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1 `CHK(stack_pointer, 5'h1f)
    for (int i = 0; i < 4; i++) begin
      seq.call_push(rows[i][19:5]);
      #1 `CHK(stack_pointer, rows[i][4:0])
    end
    // Fill past sixteen so the first slot is overwritten
    for (int j = 4; j < 17; j++) seq.call_push(15'(j));
    #1 `CHK(stack_pointer, 5'h00)
    `CHK(ovf, 1'b1)
    rd(RAS_A_LOW, 8'h10);
    wr(RAS_A_PTR, 8'h01);
    rd(RAS_A_PTR, 8'h01);
    rd(RAS_A_LOW, 8'hff);
    rd(RAS_A_HIGH, 8'h7f);
    wr(RAS_A_HIGH, 8'h55);
    wr(RAS_A_LOW, 8'haa);
    seq.ret_pop();
    #1 `CHK(pop_pc, 15'h55aa)
    `CHK(stack_pointer, 5'h00)
    seq.ret_pop();
    #1 `CHK(pop_pc, 15'h0010)
    seq.ret_pop();
    #1 `CHK(stack_pointer, 5'h1e)
    rd(RAS_A_STATUS, 8'h03);
    `CHK(rreq, 1'b0)
    wr(RAS_A_STATUS, 8'h00);
    wr(RAS_A_PTR, 8'h1f);
    rd(RAS_A_LOW, 8'h0e);
    stack_reset_enable <= 1'b1;
    rd(RAS_A_LOW, 8'h00);
    rd(RAS_A_HIGH, 8'h00);
    seq.ret_pop();
    #1 `CHK(unf, 1'b1)
    @(posedge ref_clk);
    #1 `CHK(rreq, 1'b1)
    // Mid-run reset empties the stack again, then the stack works anew
    rst <= 1'b1;
    #1 `CHK(stack_pointer, 5'h1f)
    `CHK(unf, 1'b0)
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    seq.call_push(15'h0123);
    #1 `CHK(stack_pointer, 5'h00)
    rd(RAS_A_LOW, 8'h23);
    tally_and_finish();
  end
endmodule
`default_nettype wire
